// File: sim/hdu_far_end.sv
// remote asynchronous transceiver on the serial side
// assumes the bench calls its tasks; sees the output select as buffer enable
`timescale 1ns/1ns
module hdu_far_end (
    input  wire logic clock,
    input  wire logic tx_line,
    input  wire logic tx_sel,
    output logic      rx_line
);
    logic line_q = 1'b1;
    // line idles high from the initial value of line_q
    assign rx_line = line_q;
    // start, nine data lsb first, stop; optional short glitch in bit 3
    task automatic send_char(input logic [8:0] ch, input int bclk,
                             input bit glitch);
        logic [10:0] fr;
        fr = {1'b1, ch, 1'b0};
        for (int i = 0; i < 11; i++) begin
            for (int c = 0; c < bclk; c++) begin
                @(posedge clock);
                line_q <= (glitch && i == 4 && c >= bclk / 2
                           && c < bclk / 2 + 8) ? ~fr[i] : fr[i];
            end
        end
    endtask
    // decodes an inverted frame: nine data bits then the stop bit
    task automatic recv_char(input int bclk, output logic [9:0] ch);
        while (tx_sel !== 1'b1) @(posedge clock);
        repeat (bclk + bclk / 2) @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            ch[i] = ~tx_line;
            repeat (bclk) @(posedge clock);
        end
    endtask
endmodule

// File: sim/hdu_uart_bench.sv
// self-checking bench for the nine-bit transceiver
// assumes the far-end model and the bound checker; baud 110 for frames
`timescale 1ns/1ns
module hdu_uart_bench;
    logic       clock, rst_b, reg_wr, reg_rd, port_out_bit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d;
    logic       serial_in_line, serial_out_line;
    logic       tx_output_select, tx_irq, rx_irq, nb;
    logic [9:0] got;
    logic [8:0] c1, c2, rxq[$];
    logic [31:0] seed = 32'd73698;
    int         miscompares = 0, n_checks = 0, cycles = 0, n;
    int         divs[8] = '{6656, 3328, 1664, 832, 416, 256, 208, 6656};
    hdu_uart u_hdu_uart (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port_out_bit(port_out_bit),
        .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
        .tx_output_select(tx_output_select), .tx_irq(tx_irq),
        .rx_irq(rx_irq));
    hdu_far_end u_hdu_far_end (.clock(clock), .tx_line(serial_out_line),
        .tx_sel(tx_output_select), .rx_line(serial_in_line));
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 50000) begin
            miscompares++;
            test_done();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= dat;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 dat = reg_rdata;
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        rst_b = 1'b0;
        port_out_bit = 1'b1;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        rd(8'hd7, v);
        check(v, 0);
        wr(8'hd8, 8'hff);
        rd(8'hd8, v);
        check(v, 0);
        rd(8'hd7, v);
        check(v, 0);
        @(posedge clock) port_out_bit <= 1'b0;
        repeat (3) @(posedge clock);
        #1 check(serial_out_line, 0);
        port_out_bit <= 1'b1;
        wr(8'hd7, 8'h5c);
        #1 check(tx_irq, 1);
        rd(8'hd7, v);
        check(v, 8'h5c);
        wr(8'hd7, 8'h0c);
        #1 check(tx_irq, 0);
        // two frames, ninth bit written only before the first
        for (int k = 0; k < 2; k++) begin
            d = xs();
            if (k == 0) nb = ^d;
            if (k == 0) wr(8'hd7, {7'h0e, nb});
            fork
                u_hdu_far_end.recv_char(208, got);
                wr(8'hd6, d);
            join
            check(got, {1'b1, nb, d});
            n = 0;
            while (tx_output_select !== 1'b0 && n < 400) begin
                @(posedge clock); n++;
            end
            #1 check(tx_irq, 1);
        end
        // reception into the buffer while a second char shifts in
        wr(8'hd7, 8'h2c);
        c1 = xs();
        c2 = xs();
        rxq.push_back(c1);
        rxq.push_back(c2);
        u_hdu_far_end.send_char(c1, 208, 1'b1);
        n = 0;
        while (rx_irq !== 1'b1 && n < 100) begin @(posedge clock); n++; end
        fork
            u_hdu_far_end.send_char(c2, 208, 1'b0);
            begin
                c1 = rxq.pop_front();
                rd(8'hd6, v); check(v, c1[7:0]);
                rd(8'hd7, v); check(v, {7'h56, c1[8]});
                wr(8'hd7, 8'h2c); #1 check(rx_irq, 0);
            end
        join
        n = 0;
        while (rx_irq !== 1'b1 && n < 100) begin @(posedge clock); n++; end
        c2 = rxq.pop_front();
        rd(8'hd6, v); check(v, c2[7:0]);
        rd(8'hd7, v); check(v, {7'h56, c2[8]});
        // transmission started in mid reception aborts it
        wr(8'hd7, 8'h2c);
        fork
            u_hdu_far_end.send_char(xs(), 208, 1'b0);
            begin
                repeat (700) @(posedge clock);
                wr(8'hd6, xs());
            end
        join
        n = 0;
        while (tx_output_select !== 1'b0 && n < 3000) begin
            @(posedge clock); n++;
        end
        rd(8'hd7, v); check(v[7], 0);
        // start bit width for every baud code (111 acts as 000), cut by reset
        for (int b = 0; b < 8; b++) begin
            wr(8'hd7, {4'h0, b[2:0], 1'b0});
            wr(8'hd6, 8'h01);
            #1 n = 0;
            while (serial_out_line === 1'b1 && n < 7000) begin
                @(posedge clock); n++;
            end
            check(n >= divs[b] - 1 && n <= divs[b] + 1, 1);
            rst_b <= 1'b0;
            repeat (2) @(posedge clock);
            rst_b <= 1'b1;
            rd(8'hd7, v);
            check(v, 0);
        end
        test_done();
    end
endmodule

// File: sim/hdu_uart_chk.sv
// port-level checker for the nine-bit transceiver
// assumes baud code 110 (208 clocks a bit) when frame length is judged
`timescale 1ns/1ns
module hdu_uart_chk (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       port_out_bit,
    input  wire logic       serial_in_line,
    input  wire logic       serial_out_line,
    input  wire logic       tx_output_select,
    input  wire logic       tx_irq,
    input  wire logic       rx_irq
);
    localparam int FLO = 2286;
    localparam int FHI = 2290;
    logic [11:0] frame_q;
    logic [2:0]  baud_q;
    logic        txen_q;
    wire         dwr = reg_wr && reg_addr == 8'hd6;
    wire         cwr = reg_wr && reg_addr == 8'hd7;
    // mirrors of baud code and tx enable, cycles with select high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            frame_q <= 12'h000;
            baud_q  <= 3'h0;
            txen_q  <= 1'b0;
        end else begin
            if (dwr) frame_q <= 12'h000;
            else if (tx_output_select) frame_q <= frame_q + 12'h001;
            if (cwr) baud_q <= reg_wdata[3:1];
            if (cwr) txen_q <= reg_wdata[4];
        end
    end
    a_data_starts: assert property (@(posedge clock) disable iff (!rst_b)
        dwr |=> tx_output_select && serial_out_line && !tx_irq)
        else $error("data write did not start a frame");
    a_txirq_gate: assert property (@(posedge clock) disable iff (!rst_b)
        cwr && !reg_wdata[4] |=> !tx_irq) else $error("tx irq not masked");
    a_rxirq_gate: assert property (@(posedge clock) disable iff (!rst_b)
        cwr && !reg_wdata[5] |=> !rx_irq) else $error("rx irq not masked");
    a_flag_soft_set: assert property (@(posedge clock) disable iff (!rst_b)
        cwr && reg_wdata[6] && reg_wdata[4] |=> tx_irq)
        else $error("tx empty write of one lost");
    a_port_follow: assert property (@(posedge clock) disable iff (!rst_b)
        !tx_output_select && !$past(tx_output_select) && $past(rst_b)
        |-> serial_out_line == $past(port_out_bit))
        else $error("idle pin does not follow port bit");
    a_stop_level: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(tx_output_select) |-> !$past(serial_out_line))
        else $error("stop bit not driven");
    a_frame_len: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(tx_output_select) && baud_q == 3'h6
        |-> frame_q >= FLO && frame_q <= FHI)
        else $error("frame length wrong");
    a_tx_empty_flag_sets: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(tx_output_select) && txen_q |-> ##[0:1] tx_irq)
        else $error("tx empty not set after frame");
    a_reset_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(rst_b) |-> !tx_output_select && !tx_irq && !rx_irq)
        else $error("not idle after reset");
    a_read_stands: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

bind hdu_uart hdu_uart_chk u_hdu_uart_chk (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_out_bit(port_out_bit),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .tx_output_select(tx_output_select), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// File: src/hdu_baud_gen.sv
// baud tick generator: one pulse per sampling state (8 per bit)
// assumes a single clock and synchronous use of the tick
`timescale 1ns/1ns
`include "hdu_params.svh"
module hdu_baud_gen
    import hdu_pkg::*;
#(
    parameter int DIV_W = 13
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       restart,
    input  wire logic [2:0] baud_select,
    output logic            tick
);
    // elaboration check: the slowest divisor needs thirteen bits
    if (DIV_W < 13) begin : g_bad_width
        $error("divider too narrow");
    end

    logic [DIV_W-1:0] divisor;
    logic [DIV_W-1:0] state_len;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             wrap;

    // divisor table, code 111 reserved and treated as the slowest rate
    assign divisor =
        (baud_select == 3'h0) ? DIV_W'(`HDU_DIV_000) :
        (baud_select == 3'h1) ? DIV_W'(`HDU_DIV_001) :
        (baud_select == 3'h2) ? DIV_W'(`HDU_DIV_010) :
        (baud_select == 3'h3) ? DIV_W'(`HDU_DIV_011) :
        (baud_select == 3'h4) ? DIV_W'(`HDU_DIV_100) :
        (baud_select == 3'h5) ? DIV_W'(`HDU_DIV_101) :
        (baud_select == 3'h6) ? DIV_W'(`HDU_DIV_110) :
                                DIV_W'(`HDU_DIV_000);
    // a state lasts divisor/8 clocks, so ticks run at 8x the bit rate
    assign state_len = divisor >> 3;
    assign wrap      = (cnt_q >= state_len - DIV_W'(1));
    assign cnt_d     = (restart || wrap) ? '0 : cnt_q + DIV_W'(1);
    assign tick      = wrap && !restart;

    // state counter
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// File: src/hdu_params.svh
// register offsets, field positions, reset values and divisor table
// assumes inclusion by the design modules (baud generator and transceiver)
`ifndef HDU_PARAMS_SVH
`define HDU_PARAMS_SVH

`define HDU_DATA_OFS      8'hd6
`define HDU_CTRL_OFS      8'hd7
`define HDU_RX_READY_FLAG_BIT     7
`define HDU_TX_EMPTY_FLAG_BIT      6
`define HDU_RX_IRQ_ENABLE_BIT     5
`define HDU_TX_IRQ_ENABLE_BIT     4
`define HDU_BAUD_HI       3
`define HDU_BAUD_LO       1
`define HDU_NINTH_BIT     0
`define HDU_CTRL_RESET    8'h00
`define HDU_STATES_PER_BIT 4'h8
`define HDU_DATA_BITS     4'h9
`define HDU_SAMPLE_A      3'h3
`define HDU_SAMPLE_B      3'h4
`define HDU_SAMPLE_C      3'h5
`define HDU_DIV_000       13'd6656
`define HDU_DIV_001       13'd3328
`define HDU_DIV_010       13'd1664
`define HDU_DIV_011       13'd832
`define HDU_DIV_100       13'd416
`define HDU_DIV_101       13'd256
`define HDU_DIV_110       13'd208

`endif

// File: src/hdu_pkg.sv
// types shared by the transceiver modules
// assumes the params header sits beside it
package hdu_pkg;
    typedef enum logic [1:0] {
        HDU_RX_IDLE  = 2'b00,
        HDU_RX_START = 2'b01,
        HDU_RX_DATA  = 2'b10,
        HDU_RX_STOP  = 2'b11
    } hdu_rx_state_t;

    typedef enum logic [1:0] {
        HDU_TX_IDLE  = 2'b00,
        HDU_TX_START = 2'b01,
        HDU_TX_DATA  = 2'b10,
        HDU_TX_STOP  = 2'b11
    } hdu_tx_state_t;
endpackage

// File: src/hdu_uart.sv
// half-duplex nine-bit serial transceiver with register port
// assumes a 25 MHz clock, software on a plain strobe port, and a
// port output bit supplied by the general-purpose port logic
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "hdu_params.svh"

module hdu_uart
    import hdu_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       port_out_bit,
    input  wire logic       serial_in_line,
    output logic            serial_out_line,
    output logic            tx_output_select,
    output logic            tx_irq,
    output logic            rx_irq
);
    // register decode
    logic       wr_data;
    logic       wr_ctrl;
    logic       rd_data;
    logic       rd_ctrl;
    assign wr_data = reg_wr && (reg_addr == `HDU_DATA_OFS);
    assign wr_ctrl = reg_wr && (reg_addr == `HDU_CTRL_OFS);
    assign rd_data = reg_rd && (reg_addr == `HDU_DATA_OFS);
    assign rd_ctrl = reg_rd && (reg_addr == `HDU_CTRL_OFS);

    // control state
    logic       rx_ready_flag_q;
    logic       tx_empty_flag_q;
    logic       rx_irq_enable_q;
    logic       tx_irq_enable_q;
    logic [2:0] baud_select_q;
    logic       ninth_bit_q;
    logic [7:0] rx_buf_q;
    logic [7:0] reg_rdata_q;

    // input synchroniser: three flops, change taken when 2 and 3 agree
    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;
    logic       rx_level_q;
    logic       rx_level_d;
    assign rx_level_d = (sync2_q == sync3_q) ? sync3_q : rx_level_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q    <= 1'b1;
            sync2_q    <= 1'b1;
            sync3_q    <= 1'b1;
            rx_level_q <= 1'b1;
        end else begin
            sync1_q    <= serial_in_line;
            sync2_q    <= sync1_q;
            sync3_q    <= sync2_q;
            rx_level_q <= rx_level_d;
        end
    end

    // transmitter state
    hdu_tx_state_t tx_st_q;
    hdu_tx_state_t tx_st_d;
    logic [8:0]    tx_sh_q;
    logic [8:0]    tx_sh_d;
    logic [2:0]    tx_ph_q;
    logic [2:0]    tx_ph_d;
    logic [3:0]    tx_bit_q;
    logic [3:0]    tx_bit_d;
    logic          tx_line;
    logic          tx_done;

    // receiver state
    hdu_rx_state_t rx_st_q;
    hdu_rx_state_t rx_st_d;
    logic [8:0]    rx_sh_q;
    logic [8:0]    rx_sh_d;
    logic [2:0]    rx_ph_q;
    logic [2:0]    rx_ph_d;
    logic [3:0]    rx_bit_q;
    logic [3:0]    rx_bit_d;
    logic [2:0]    votes_q;
    logic [2:0]    votes_d;
    logic          rx_prev_q;
    logic          rx_fall;
    logic          rx_done;
    logic          voted;

    // shared baud generator; restarted by a new transfer
    logic          tick;
    logic          tx_start;
    logic          bg_restart;
    assign tx_start   = wr_data;
    assign rx_fall    = rx_prev_q && !rx_level_q
                        && (rx_st_q == HDU_RX_IDLE)
                        && (tx_st_q == HDU_TX_IDLE);
    assign bg_restart = tx_start || rx_fall;

    hdu_baud_gen #(
        .DIV_W(13)
    ) u_baud (
        .clock      (clock),
        .rst_b      (rst_b),
        .restart    (bg_restart),
        .baud_select(baud_select_q),
        .tick       (tick)
    );

    // transmit sequencer: start, nine data bits, stop
    logic tx_last_ph;
    assign tx_last_ph = tick && (tx_ph_q == 3'h7);

    always_comb begin
        tx_st_d  = tx_st_q;
        tx_sh_d  = tx_sh_q;
        tx_bit_d = tx_bit_q;
        tx_ph_d  = tick ? tx_ph_q + 3'h1 : tx_ph_q;
        tx_done  = 1'b0;
        case (tx_st_q)
            HDU_TX_IDLE: begin
                tx_ph_d = 3'h0;
            end
            HDU_TX_START: begin
                if (tx_last_ph) begin
                    tx_st_d  = HDU_TX_DATA;
                    tx_bit_d = 4'h0;
                end
            end
            HDU_TX_DATA: begin
                if (tx_last_ph) begin
                    tx_sh_d  = {1'b0, tx_sh_q[8:1]};
                    tx_bit_d = tx_bit_q + 4'h1;
                    if (tx_bit_q == `HDU_DATA_BITS - 4'h1) begin
                        tx_st_d = HDU_TX_STOP;
                    end
                end
            end
            HDU_TX_STOP: begin
                if (tx_last_ph) begin
                    tx_st_d = HDU_TX_IDLE;
                    tx_done = 1'b1;
                end
            end
            default: begin
                tx_st_d = HDU_TX_IDLE;
            end
        endcase
        // a data write always restarts the character
        if (tx_start) begin
            tx_st_d = HDU_TX_START;
            tx_sh_d = {ninth_bit_q, reg_wdata};
            tx_ph_d = 3'h0;
        end
    end

    assign tx_line = (tx_st_q == HDU_TX_START) ? 1'b0 :
                     (tx_st_q == HDU_TX_DATA)  ? tx_sh_q[0] : 1'b1;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q  <= HDU_TX_IDLE;
            tx_sh_q  <= '0;
            tx_ph_q  <= '0;
            tx_bit_q <= '0;
        end else begin
            tx_st_q  <= tx_st_d;
            tx_sh_q  <= tx_sh_d;
            tx_ph_q  <= tx_ph_d;
            tx_bit_q <= tx_bit_d;
        end
    end

    // output mux and inversion, registered
    logic out_q;
    logic sel_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            sel_q <= (tx_st_d != HDU_TX_IDLE);
            out_q <= (tx_st_d != HDU_TX_IDLE) ?
                     !((tx_st_d == HDU_TX_START) ? 1'b0 :
                       (tx_st_d == HDU_TX_DATA) ? tx_sh_d[0] : 1'b1)
                     : port_out_bit;
        end
    end
    assign serial_out_line  = out_q;
    assign tx_output_select = sel_q;

    // majority of the samples in states 3, 4 and 5
    assign voted = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2])
                 | (votes_q[1] & votes_q[2]);

    // receive sequencer
    logic rx_last_ph;
    logic rx_abort;
    assign rx_last_ph = tick && (rx_ph_q == 3'h7);
    assign rx_abort   = tx_start || (tx_st_q != HDU_TX_IDLE);

    always_comb begin
        rx_st_d  = rx_st_q;
        rx_sh_d  = rx_sh_q;
        rx_bit_d = rx_bit_q;
        rx_ph_d  = tick ? rx_ph_q + 3'h1 : rx_ph_q;
        votes_d  = votes_q;
        rx_done  = 1'b0;
        if (tick && (rx_ph_q == `HDU_SAMPLE_A)) votes_d[0] = rx_level_q;
        if (tick && (rx_ph_q == `HDU_SAMPLE_B)) votes_d[1] = rx_level_q;
        if (tick && (rx_ph_q == `HDU_SAMPLE_C)) votes_d[2] = rx_level_q;
        case (rx_st_q)
            HDU_RX_IDLE: begin
                rx_ph_d = 3'h0;
                if (rx_fall) begin
                    rx_st_d = HDU_RX_START;
                end
            end
            HDU_RX_START: begin
                if (rx_last_ph) begin
                    rx_st_d  = HDU_RX_DATA;
                    rx_bit_d = 4'h0;
                end
            end
            HDU_RX_DATA: begin
                if (rx_last_ph) begin
                    rx_sh_d  = {voted, rx_sh_q[8:1]};
                    rx_bit_d = rx_bit_q + 4'h1;
                    if (rx_bit_q == `HDU_DATA_BITS - 4'h1) begin
                        rx_st_d = HDU_RX_STOP;
                    end
                end
            end
            HDU_RX_STOP: begin
                if (rx_last_ph) begin
                    rx_st_d = HDU_RX_IDLE;
                    rx_done = 1'b1;
                end
            end
            default: begin
                rx_st_d = HDU_RX_IDLE;
            end
        endcase
        if (rx_abort) begin
            rx_st_d = HDU_RX_IDLE;
            rx_done = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q   <= HDU_RX_IDLE;
            rx_sh_q   <= '0;
            rx_ph_q   <= '0;
            rx_bit_q  <= '0;
            votes_q   <= 3'h7;
            rx_prev_q <= 1'b1;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_sh_q   <= rx_sh_d;
            rx_ph_q   <= rx_ph_d;
            rx_bit_q  <= rx_bit_d;
            votes_q   <= votes_d;
            rx_prev_q <= rx_level_q;
        end
    end

    // flags: hardware set wins over a software clear
    logic rx_ready_flag_d;
    logic tx_empty_flag_d;
    assign rx_ready_flag_d = rx_done ? 1'b1 :
                     wr_ctrl ? reg_wdata[`HDU_RX_READY_FLAG_BIT] :
                     rx_ready_flag_q;
    assign tx_empty_flag_d  = tx_done ? 1'b1 :
                     tx_start ? 1'b0 :
                     wr_ctrl ? reg_wdata[`HDU_TX_EMPTY_FLAG_BIT] :
                     tx_empty_flag_q;

    // control register, receive buffer and ninth bit
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_ready_flag_q <= 1'b0;
            tx_empty_flag_q <= 1'b0;
            rx_irq_enable_q <= 1'b0;
            tx_irq_enable_q <= 1'b0;
            baud_select_q   <= 3'h0;
            ninth_bit_q     <= 1'b0;
            rx_buf_q        <= 8'h00;
        end else begin
            rx_ready_flag_q <= rx_ready_flag_d;
            tx_empty_flag_q <= tx_empty_flag_d;
            if (wr_ctrl) begin
                rx_irq_enable_q <= reg_wdata[`HDU_RX_IRQ_ENABLE_BIT];
                tx_irq_enable_q <= reg_wdata[`HDU_TX_IRQ_ENABLE_BIT];
                baud_select_q   <=
                    reg_wdata[`HDU_BAUD_HI:`HDU_BAUD_LO];
            end
            if (rx_done) begin
                rx_buf_q    <= rx_sh_q[7:0];
                ninth_bit_q <= rx_sh_q[8];
            end else if (wr_ctrl) begin
                ninth_bit_q <= reg_wdata[`HDU_NINTH_BIT];
            end
        end
    end

    // read data, registered one cycle after the strobe
    logic [7:0] ctrl_view;
    assign ctrl_view = {rx_ready_flag_q, tx_empty_flag_q, rx_irq_enable_q,
                        tx_irq_enable_q, baud_select_q, ninth_bit_q};
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rd_data ? rx_buf_q :
                           rd_ctrl ? ctrl_view : 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // interrupt requests, each flag with its own enable; clock never
    // gated so these work in wait mode
    assign tx_irq = tx_empty_flag_q && tx_irq_enable_q;
    assign rx_irq = rx_ready_flag_q && rx_irq_enable_q;
endmodule
